// ### bench/standby_wake_timer_props.sv
`timescale 1ns/1ns
module standby_wake_timer_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic sleep_instr_i,
	input wire logic wake_irq_i,
	input wire logic speed_up_i,
	input wire logic subactive_i,
	input wire logic cpu_clk_en_o,
	input wire logic bus_hiz_o,
	input wire logic bus_hold_o,
	input wire logic standby_o,
	input wire logic software_standby_select_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic wr_q;
	logic wr2_q;
	logic rd_ctl_q;
	// recent writes: the select bit may lag a write by up to two edges
	always_ff @(posedge clk_i) begin
		wr_q <= cyc_i & stb_i & we_i;
		wr2_q <= wr_q;
		rd_ctl_q <= cyc_i & stb_i & !we_i & !ack_o & (adr_i == 4'h0);
	end
	sequence run_sleep;
		sleep_instr_i && cpu_clk_en_o;
	endsequence
	sequence run_speed_up;
		speed_up_i && subactive_i && cpu_clk_en_o;
	endsequence
	chk_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack one cycle after request");
	chk_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_low_read_zero: assert property (ack_o && rd_ctl_q |-> dat_o[2:0] == 3'h0)
		else $error("reserved control bits read nonzero");
	chk_bus_exclusive: assert property (!(bus_hiz_o && bus_hold_o))
		else $error("bus both floated and held");
	chk_standby_bus: assert property (run_sleep ##0 software_standby_select_o |=>
		standby_o && (bus_hiz_o != bus_hold_o))
		else $error("standby entry without bus treatment");
	chk_clock_gated: assert property (standby_o |-> !cpu_clk_en_o)
		else $error("cpu clock running in standby or wake wait");
	chk_speed_wait: assert property (run_speed_up |=> !cpu_clk_en_o [*8])
		else $error("speed up released clock without wait");
	chk_sleep_stops: assert property (run_sleep |=> !cpu_clk_en_o)
		else $error("sleep did not stop cpu clock");
	chk_software_standby_select_changes: assert property ($changed(software_standby_select_o) |->
		wr_q || wr2_q)
		else $error("standby select changed without a write");
endmodule

bind standby_wake_timer standby_wake_timer_props u_props (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
	.sleep_instr_i(sleep_instr_i), .wake_irq_i(wake_irq_i), .speed_up_i(speed_up_i),
	.subactive_i(subactive_i), .cpu_clk_en_o(cpu_clk_en_o), .bus_hiz_o(bus_hiz_o),
	.bus_hold_o(bus_hold_o), .standby_o(standby_o),
	.software_standby_select_o(software_standby_select_o));

// ### bench/standby_wake_timer_test.sv
`timescale 1ns/1ns
module standby_wake_timer_test;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, sleep_instr_i, wake_irq_i, speed_up_i;
	logic subactive_i, direct_transition_i, ack_o, cpu_clk_en_o, bus_hiz_o, bus_hold_o;
	logic standby_o, software_standby_select_o;
	logic [3:0] adr_i, sel_i;
	logic [31:0] dat_i, dat_o, rd;
	int error_cnt, comparisons, cycles, n;
	// codes 000 and 111 run at their full length; the rest are shortened to keep the run brief
	// code 110 runs as long as 101
	localparam int WL[8] = '{8192, 24, 28, 32, 36, 40, 40, 16};
	standby_wake_timer #(.WAIT_CODE1(19'd24), .WAIT_CODE2(19'd28), .WAIT_CODE3(19'd32),
		.WAIT_CODE4(19'd36), .WAIT_CODE5(19'd40)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.sleep_instr_i(sleep_instr_i), .wake_irq_i(wake_irq_i), .speed_up_i(speed_up_i),
		.subactive_i(subactive_i), .direct_transition_i(direct_transition_i),
		.cpu_clk_en_o(cpu_clk_en_o), .bus_hiz_o(bus_hiz_o), .bus_hold_o(bus_hold_o),
		.standby_o(standby_o), .software_standby_select_o(software_standby_select_o));
	// clock
	always #10 clk_i = ~clk_i;
	task summarize();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// one wishbone classic cycle; waits for ack under a bound
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 20);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (k >= 20) chk(0, 1);
	endtask
	// one-cycle event pulse: 0 sleep, 1 wake interrupt, 2 speed up
	task ev(input int k);
		@(posedge clk_i);
		case (k)
			0: sleep_instr_i <= 1'b1;
			1: wake_irq_i <= 1'b1;
			default: speed_up_i <= 1'b1;
		endcase
		@(posedge clk_i);
		sleep_instr_i <= 1'b0;
		wake_irq_i <= 1'b0;
		speed_up_i <= 1'b0;
		#1;
	endtask
	// counts edges from the wake edge until the cpu clock returns, which is after edge l + 1
	task wake_len(input int l);
		n = 0;
		while (cpu_clk_en_o !== 1'b1 && n < 9000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk(n, l + 1);
	endtask
	// hang guard well beyond the expected run length
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			error_cnt++;
			summarize();
		end
	end
	initial begin
		{clk_i, cyc_i, stb_i, we_i, sleep_instr_i, wake_irq_i, speed_up_i} = '0;
		{subactive_i, direct_transition_i, adr_i, sel_i, dat_i} = '0;
		{error_cnt, comparisons, cycles} = '0;
		rst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, 4'h0, 0, 4'hf);
		chk(rd, 32'h48);
		wb(1, 4'h0, 32'hff, 4'h0);
		wb(0, 4'h0, 0, 4'hf);
		chk(rd, 32'h48);
		wb(1, 4'h8, 32'hff, 4'hf);
		wb(0, 4'h8, 0, 4'hf);
		chk(rd, 32'h0);
		$display("test registers done");
		// the bench stands for an external clock, so every code may be picked
		// no crystal is modelled, so the 16-state code is allowed here
		for (int c = 0; c < 8; c++) begin
			wb(1, 4'h0, {24'h0, 1'b1, 3'(c), c[0], 3'b111}, 4'h1);
			wb(0, 4'h0, 0, 4'hf);
			chk(rd, {24'h0, 1'b1, 3'(c), c[0], 3'b000});
			ev(0);
			chk(standby_o, 1);
			chk({bus_hold_o, bus_hiz_o}, {c[0], !c[0]});
			ev(1);
			wake_len(WL[c]);
			chk(software_standby_select_o, 1);
			$display("test wait code %0d done", c);
		end
		wb(1, 4'h0, 32'h08, 4'h1);
		ev(0);
		chk({standby_o, cpu_clk_en_o}, 0);
		wb(0, 4'h4, 0, 4'hf);
		chk(rd, 32'h1);
		ev(1);
		chk(cpu_clk_en_o, 1);
		$display("test plain sleep done");
		wb(1, 4'h0, 32'h78, 4'h1);
		subactive_i <= 1'b1;
		ev(2);
		wake_len(16);
		subactive_i <= 1'b0;
		$display("test speed up done");
		wb(1, 4'h0, 32'hf8, 4'h1);
		direct_transition_i <= 1'b1;
		ev(0);
		ev(1);
		wake_len(16);
		chk(bus_hold_o, 1);
		chk(bus_hiz_o, 0);
		$display("test direct transition done");
		summarize();
	end
endmodule

// ### hw/standby_wake_cfg.svh
`ifndef STANDBY_WAKE_CFG_SVH
`define STANDBY_WAKE_CFG_SVH

// register byte offsets on the wishbone bus
`define SWT_OFS_CONTROL 4'h0
`define SWT_OFS_STATUS 4'h4

// control register fields
`define SWT_BIT_SOFTWARE_STANDBY_SELECT 7
`define SWT_SEL_HI 6
`define SWT_SEL_LO 4
`define SWT_BIT_OPE 3

// control register reset value: wait code 100, bus hold on, standby off
`define SWT_CONTROL_RESET 8'h48

// status register fields
`define SWT_ST_STATE_HI 1
`define SWT_ST_STATE_LO 0
`define SWT_ST_BUSY 2
`define SWT_ST_HIZ 3
`define SWT_ST_HOLD 4
`define SWT_ST_REM_LO 8
`define SWT_ST_REM_HI 26

// wake wait lengths in system clock states
`define SWT_WAIT_CODE0 19'h02000
`define SWT_WAIT_CODE1 19'h04000
`define SWT_WAIT_CODE2 19'h08000
`define SWT_WAIT_CODE3 19'h10000
`define SWT_WAIT_CODE4 19'h20000
`define SWT_WAIT_CODE5 19'h40000
`define SWT_WAIT_CODE7 19'h00010

`endif

// ### hw/standby_wake_pkg.sv
package standby_wake_pkg;

	// power state of the wake controller
	typedef enum logic [1:0] {
		ST_RUN,
		ST_SLEEP,
		ST_STANDBY,
		ST_WAKE_WAIT
	} power_state_t;

	// wake wait selection code
	typedef logic [2:0] wait_code_t;

	// count of system clock states
	typedef logic [18:0] state_count_t;

endpackage

// ### hw/standby_wake_timer.sv
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "standby_wake_cfg.svh"

// Behaviour
// - wait codes give 8192..262144 states or 16; code 110 is reserved
// - wake wait inserted when standby, watch or subactive ends
// - hold enable keeps bus outputs or floats them in standby and watch
// - same hold or float choice applies during a direct transition
// - low three control bits read zero and ignore writes
// - standby select picks the sleep target; interrupt wakes leave it unchanged
module standby_wake_timer #(
	parameter standby_wake_pkg::state_count_t WAIT_CODE0 = `SWT_WAIT_CODE0,
	parameter standby_wake_pkg::state_count_t WAIT_CODE1 = `SWT_WAIT_CODE1,
	parameter standby_wake_pkg::state_count_t WAIT_CODE2 = `SWT_WAIT_CODE2,
	parameter standby_wake_pkg::state_count_t WAIT_CODE3 = `SWT_WAIT_CODE3,
	parameter standby_wake_pkg::state_count_t WAIT_CODE4 = `SWT_WAIT_CODE4,
	parameter standby_wake_pkg::state_count_t WAIT_CODE5 = `SWT_WAIT_CODE5
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// cpu side events
	input wire logic sleep_instr_i,
	input wire logic wake_irq_i,
	input wire logic speed_up_i,
	input wire logic subactive_i,
	input wire logic direct_transition_i,
	// clock and bus pin control
	output logic cpu_clk_en_o,
	output logic bus_hiz_o,
	output logic bus_hold_o,
	output logic standby_o,
	output logic software_standby_select_o
);

	// control register fields
	logic software_standby_select_q;
	standby_wake_pkg::wait_code_t wake_wait_sel_q;
	logic bus_output_hold_enable_q;

	// reset image of the control register, a vector so each field can be picked from it
	localparam logic [7:0] CONTROL_RESET = `SWT_CONTROL_RESET;

	// power state
	standby_wake_pkg::power_state_t state_q;
	standby_wake_pkg::power_state_t state_d;
	logic pins_treated;

	// wake wait counter link
	logic wait_start;
	logic wait_busy;
	logic wait_done;
	standby_wake_pkg::state_count_t wait_load;
	standby_wake_pkg::state_count_t wait_remaining;

	// bus slave
	logic bus_req;
	logic wr_ctrl;
	logic ctrl_hit;
	logic [7:0] control_rd;
	logic [31:0] status_rd;
	logic [31:0] rd_d;

	// registered outputs
	logic ack_q;
	logic [31:0] dat_q;
	logic cpu_clk_en_q;
	logic bus_hiz_q;
	logic bus_hold_q;
	logic standby_q;

	// a new request is taken only while no ack is pending, so acks come at most every second cycle
	// a master that keeps stb up after ack is therefore taken again in the cycle after the ack
	assign bus_req = cyc_i && stb_i && !ack_q;

	// the register lives in byte lane 0; writes on the other lanes are dropped
	assign ctrl_hit = adr_i == `SWT_OFS_CONTROL && sel_i[0];
	assign wr_ctrl = bus_req && we_i && ctrl_hit;

	// standby select bit
	// only software writes change it; interrupt wakes never touch it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			software_standby_select_q <= CONTROL_RESET[`SWT_BIT_SOFTWARE_STANDBY_SELECT];
		end else if (wr_ctrl) begin
			software_standby_select_q <= dat_i[`SWT_BIT_SOFTWARE_STANDBY_SELECT];
		end
	end

	// wake wait selection field
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_wait_sel_q <= CONTROL_RESET[`SWT_SEL_HI:`SWT_SEL_LO];
		end else if (wr_ctrl) begin
			wake_wait_sel_q <= dat_i[`SWT_SEL_HI:`SWT_SEL_LO];
		end
	end

	// bus output hold enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_output_hold_enable_q <= CONTROL_RESET[`SWT_BIT_OPE];
		end else if (wr_ctrl) begin
			bus_output_hold_enable_q <= dat_i[`SWT_BIT_OPE];
		end
	end

	// reserved bits
	// bits 2 to 0 have no storage, so writes vanish and reads return zero
	assign control_rd = {software_standby_select_q, wake_wait_sel_q,
		bus_output_hold_enable_q, 3'h0};

	// status word: state, counter activity, pin control and remaining states
	always_comb begin
		status_rd = 32'h00000000;
		status_rd[`SWT_ST_STATE_HI:`SWT_ST_STATE_LO] = state_q;
		status_rd[`SWT_ST_BUSY] = wait_busy;
		status_rd[`SWT_ST_HIZ] = bus_hiz_q;
		status_rd[`SWT_ST_HOLD] = bus_hold_q;
		status_rd[`SWT_ST_REM_HI:`SWT_ST_REM_LO] = wait_remaining;
	end

	// read mux; unmapped offsets read as zero and still get an ack
	always_comb begin
		unique case (adr_i)
			`SWT_OFS_CONTROL: rd_d = {24'h000000, control_rd};
			`SWT_OFS_STATUS: rd_d = status_rd;
			default: rd_d = 32'h00000000;
		endcase
	end

	// ack one cycle after the request, dropped in the following cycle
	// ack is a registered copy of the request, so the answer never depends on the address
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req;
		end
	end

	// read data is captured with the ack and held until the next read
	// writes leave the last read value in place, so a slow master can still pick it up
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h00000000;
		end else if (bus_req && !we_i) begin
			dat_q <= rd_d;
		end
	end

	// wait decode
	// the reserved code has no defined wait; the longest wait is used as the safe choice
	always_comb begin
		unique case (wake_wait_sel_q)
			3'h0: wait_load = WAIT_CODE0;
			3'h1: wait_load = WAIT_CODE1;
			3'h2: wait_load = WAIT_CODE2;
			3'h3: wait_load = WAIT_CODE3;
			3'h4: wait_load = WAIT_CODE4;
			3'h5: wait_load = WAIT_CODE5;
			// reserved code falls back to the longest wait
			3'h6: wait_load = WAIT_CODE5;
			3'h7: wait_load = `SWT_WAIT_CODE7;
		endcase
	end

	// wake start
	// standby or watch ended by an interrupt, or subactive left by a speed-up
	// the crystal and pll limits on the chosen code are software's to respect
	// a plain sleep never stopped the oscillator, so it needs no wait
	assign wait_start = (state_q == standby_wake_pkg::ST_STANDBY && wake_irq_i) ||
		(state_q == standby_wake_pkg::ST_RUN && subactive_i && speed_up_i);

	// state counter
	// a start during the wait reloads the count rather than cutting it short
	wake_wait_counter u_wait (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(wait_start),
		.load_i(wait_load),
		.busy_o(wait_busy),
		.done_o(wait_done),
		.remaining_o(wait_remaining)
	);

	// sleep target
	// standby select chooses standby or watch over plain sleep
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			standby_wake_pkg::ST_RUN: begin
				// a wake start wins over a sleep pulse in the same cycle
				if (wait_start) begin
					state_d = standby_wake_pkg::ST_WAKE_WAIT;
				end else if (sleep_instr_i && software_standby_select_q) begin
					state_d = standby_wake_pkg::ST_STANDBY;
				end else if (sleep_instr_i) begin
					state_d = standby_wake_pkg::ST_SLEEP;
				end
			end
			standby_wake_pkg::ST_SLEEP: begin
				// the oscillator never stopped, so no wait is needed
				if (wake_irq_i) begin
					state_d = standby_wake_pkg::ST_RUN;
				end
			end
			standby_wake_pkg::ST_STANDBY: begin
				// a sleep pulse here is ignored; only a wake starts the wait
				if (wait_start) begin
					state_d = standby_wake_pkg::ST_WAKE_WAIT;
				end
			end
			standby_wake_pkg::ST_WAKE_WAIT: begin
				// interrupts during the wait are left to the cpu once it runs again
				// release after count
				if (wait_done) begin
					state_d = standby_wake_pkg::ST_RUN;
				end
			end
		endcase
	end

	// power state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= standby_wake_pkg::ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// cpu clock gate
	// the cpu clock stays off until the full wait has been counted
	// the gate follows the next state, so the clock stops on the edge that ends run
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_clk_en_q <= 1'b1;
		end else begin
			cpu_clk_en_q <= state_d == standby_wake_pkg::ST_RUN;
		end
	end

	// standby indicator covers the stopped period and the wake wait
	// watch and software standby share one state here; the sleep target does not tell them apart
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			standby_q <= 1'b0;
		end else begin
			standby_q <= state_d == standby_wake_pkg::ST_STANDBY ||
				state_d == standby_wake_pkg::ST_WAKE_WAIT;
		end
	end

	// standby, the wake wait and a direct move all ask for the bus pin treatment
	assign pins_treated = state_d == standby_wake_pkg::ST_STANDBY ||
		state_d == standby_wake_pkg::ST_WAKE_WAIT || direct_transition_i;

	// direct move floated
	// pins keep their treatment until the cpu clock is back, so no glitch precedes the wake
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_hiz_q <= 1'b0;
		end else begin
			bus_hiz_q <= pins_treated && !bus_output_hold_enable_q;
		end
	end

	// direct move held
	// hold and float read the same enable bit, so they can never both be on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_hold_q <= 1'b0;
		end else begin
			bus_hold_q <= pins_treated && bus_output_hold_enable_q;
		end
	end

	// every output comes straight from a flip-flop
	assign ack_o = ack_q;
	assign dat_o = dat_q;
	assign cpu_clk_en_o = cpu_clk_en_q;
	assign bus_hiz_o = bus_hiz_q;
	assign bus_hold_o = bus_hold_q;
	assign standby_o = standby_q;
	assign software_standby_select_o = software_standby_select_q;

endmodule

// ### hw/wake_wait_counter.sv
`timescale 1ns/1ns

module wake_wait_counter (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire standby_wake_pkg::state_count_t load_i,
	output logic busy_o,
	output logic done_o,
	output standby_wake_pkg::state_count_t remaining_o
);

	standby_wake_pkg::state_count_t count_q;
	logic busy_q;
	logic done_q;

	// down counter; a start while busy reloads, so a late wake never shortens the wait
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_q <= '0;
		end else if (start_i) begin
			count_q <= load_i - 19'h00001;
		end else if (busy_q && count_q != '0) begin
			count_q <= count_q - 19'h00001;
		end
	end

	// busy from start until the last state has been counted
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_q <= 1'b0;
		end else if (start_i) begin
			busy_q <= 1'b1;
		end else if (busy_q && count_q == '0) begin
			busy_q <= 1'b0;
		end
	end

	// one-cycle pulse when the wait has elapsed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_q <= 1'b0;
		end else begin
			done_q <= busy_q && !start_i && count_q == '0;
		end
	end

	assign busy_o = busy_q;
	assign done_o = done_q;
	assign remaining_o = count_q;

endmodule
